// ---- aos_pkg.sv ----
`default_nettype none
// **********************************************************************
// Analogue output scaling: shared constants
// **********************************************************************
package aos_pkg;

	// Clock and time base
	localparam int unsigned CLK_HZ       = 250_000_000;
	localparam int unsigned TENTH_MS     = 100;                          // Tick period in ms
	localparam int unsigned TENTH_CYCLES = CLK_HZ / 1000 * TENTH_MS;     // Cycles per 0.1 s
	localparam int unsigned TENTHS_PER_S = 10;

	// Widths
	localparam int unsigned VAL_W = 24;                                  // Signed display value
	localparam int unsigned OUT_W = 16;                                  // Code in uA or mV

	// Output stage kinds
	localparam int unsigned KIND_ACT_I = 0;
	localparam int unsigned KIND_PAS_I = 1;
	localparam int unsigned KIND_ACT_V = 2;

	// Output modes
	localparam logic [2:0] MODE_OFF   = 3'h0;
	localparam logic [2:0] MODE_0_20  = 3'h1;
	localparam logic [2:0] MODE_4_20  = 3'h2;
	localparam logic [2:0] MODE_0_5   = 3'h3;
	localparam logic [2:0] MODE_1_5   = 3'h4;
	localparam logic [2:0] MODE_0_10  = 3'h5;
	localparam logic [2:0] MODE_2_10  = 3'h6;
	localparam logic [2:0] MODE_BUS   = 3'h7;

	// Range limits, uA for current and mV for voltage
	localparam logic [15:0] LIM_ZERO  = 16'h0000;
	localparam logic [15:0] LIM_4MA   = 16'h0fa0;                        // 4000 uA
	localparam logic [15:0] LIM_20MA  = 16'h4e20;                        // 20000 uA
	localparam logic [15:0] LIM_1V    = 16'h03e8;                        // 1000 mV
	localparam logic [15:0] LIM_2V    = 16'h07d0;                        // 2000 mV
	localparam logic [15:0] LIM_5V    = 16'h1388;                        // 5000 mV
	localparam logic [15:0] LIM_10V   = 16'h2710;                        // 10000 mV

	// Fault levels
	localparam logic [15:0] FLT_22_1MA = 16'h5654;                       // 22100 uA
	localparam logic [15:0] FLT_3_4MA  = 16'h0d48;                       // 3400 uA
	localparam logic [15:0] FLT_11V    = 16'h2af8;                       // 11000 mV
	localparam logic [15:0] FLT_5_5V   = 16'h157c;                       // 5500 mV
	localparam logic [15:0] FLT_1_2V   = 16'h04b0;                       // 1200 mV
	localparam logic [15:0] FLT_0_6V   = 16'h0258;                       // 600 mV

	// Fault action codes
	localparam logic [2:0] ACT_KEEP = 3'h0;
	localparam logic [2:0] ACT_MAX_ACT_I = 3'h3;
	localparam logic [2:0] ACT_MAX_PAS_I = 3'h2;
	localparam logic [2:0] ACT_MAX_ACT_V = 3'h5;

	// Range extensions in 0.001 % steps
	localparam logic [16:0] EXT_MAX_LO_ACT = 17'h1869f;                  // 99.999 %
	localparam logic [16:0] EXT_MAX_LO_PAS = 17'h0752f;                  // 29.999 %
	localparam logic [16:0] EXT_MAX_HI_I   = 17'h04e1f;                  // 19.999 %
	localparam logic [16:0] EXT_MAX_HI_V   = 17'h0270f;                  // 9.999 %
	localparam logic [31:0] EXT_SCALE      = 32'h000186a0;               // 100000

	// Other setting limits
	localparam logic [6:0] TIMEOUT_MAX = 7'h63;                          // 99 s
	localparam logic [7:0] HOLD_MAX    = 8'hc7;                          // 19.9 s

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_LOW_PT    = 8'h04;
	localparam logic [7:0] OFS_HIGH_PT   = 8'h08;
	localparam logic [7:0] OFS_EXT_LOW   = 8'h0c;
	localparam logic [7:0] OFS_EXT_HIGH  = 8'h10;
	localparam logic [7:0] OFS_BUS_LEVEL = 8'h14;
	localparam logic [7:0] OFS_TIMEOUT   = 8'h18;
	localparam logic [7:0] OFS_PEAK_THR  = 8'h1c;
	localparam logic [7:0] OFS_HOLD_TIME = 8'h20;
	localparam logic [7:0] OFS_STATUS    = 8'h24;
	localparam logic [7:0] OFS_CMD       = 8'h28;
	localparam logic [7:0] OFS_OUT_CODE  = 8'h2c;

	// Control register fields
	localparam int unsigned CTRL_MODE_LSB = 0;                           // [2:0]
	localparam int unsigned CTRL_SRC_BIT  = 3;
	localparam int unsigned CTRL_INV_BIT  = 4;
	localparam int unsigned CTRL_ACT_LSB  = 5;                           // [7:5]
	localparam int unsigned CMD_REL_BIT   = 0;

	// Reset values
	localparam logic [23:0] RST_LOW_PT   = 24'h000000;
	localparam logic [23:0] RST_HIGH_PT  = 24'h0003e8;
	localparam logic [23:0] RST_PEAK_THR = 24'h00000a;

endpackage
`default_nettype wire

// ---- aos_analog_out.sv ----
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Active current output offers off, 0-20 mA, 4-20 mA and bus mode.
// - Passive current output offers only off, 4-20 mA and bus mode.
// - Active voltage output offers off, 0-5, 1-5, 0-10, 2-10 V and bus.
// - Bus mode takes the level from the serial bus, not the measurement.
// - Output = (source - low) / (high - low) * span + lower limit.
// - Upper limit 20 mA, 5 V or 10 V; lower 0, 4 mA, 0, 1 or 2 V.
// - Low point above high point is allowed and inverts the mapping.
// - Computed values outside the borders saturate at the nearer border.
// - Borders extend the limits by percentages of 0.001 % resolution.
// - Low extension at most 99.999 %, or 29.999 % for passive current.
// - High extension at most 19.999 % for current, 9.999 % for voltage.
// - Current fault action: keep, 22.1, 3.4 or 0 mA; no 0 mA passive.
// - Voltage fault action: keep, 11, 5.5, 1.2, 0.6 or 0 V.
// - After the fault ends the normal computed level returns.
// - Source select picks live value or held peak/drop value.
// - Frame gap above timeout puts bus mode in alert; zero disables it.
// - Peak detection finds peaks or drops of at least the threshold.
// - Detected value is held 0.1-19.9 s in 0.1 s steps; zero holds it until release.
module aos_analog_out
	import aos_pkg::*;
#(
	parameter int unsigned OUT_KIND  = KIND_ACT_I,
	parameter int unsigned TENTH_CYC = TENTH_CYCLES
) (
	// Clock and reset
	input  wire logic               CLOCK,
	input  wire logic               RST_N,
	// Register port
	input  wire logic [7:0]         REG_ADDR,
	input  wire logic [31:0]        REG_WDATA,
	input  wire logic               REG_WR,
	input  wire logic               REG_RD,
	output logic      [31:0]        REG_RDATA,
	// Measurement and link events
	input  wire logic [VAL_W-1:0]   MEAS_VALUE,
	input  wire logic               FRAME_RX,
	input  wire logic               FAULT_IN,
	// Output stage
	output logic      [OUT_W-1:0]   OUT_CODE,
	output logic                    OUT_ENABLE,
	output logic                    BUS_ALERT
);

	// **********************************************************************
	// Helper functions
	// **********************************************************************

	// Modes the fitted stage supports
	function automatic logic mode_ok(input logic [2:0] m);
		case (OUT_KIND)
			KIND_ACT_I: mode_ok = (m == MODE_OFF) || (m == MODE_0_20) ||
				(m == MODE_4_20) || (m == MODE_BUS);
			KIND_PAS_I: mode_ok = (m == MODE_OFF) || (m == MODE_4_20) ||
				(m == MODE_BUS);
			default: mode_ok = (m == MODE_OFF) || (m == MODE_BUS) ||
				((m >= MODE_0_5) && (m <= MODE_2_10));
		endcase
	endfunction

	// Lower range limit
	function automatic logic [15:0] low_limit(input logic [2:0] m);
		case (m)
			MODE_4_20: low_limit = LIM_4MA;
			MODE_1_5:  low_limit = LIM_1V;
			MODE_2_10: low_limit = LIM_2V;
			MODE_BUS:  low_limit = (OUT_KIND == KIND_PAS_I) ? LIM_4MA : LIM_ZERO;
			default:   low_limit = LIM_ZERO;
		endcase
	endfunction

	// Upper range limit; bus mode spans the stage's full range
	function automatic logic [15:0] high_limit(input logic [2:0] m);
		case (m)
			MODE_0_20, MODE_4_20: high_limit = LIM_20MA;
			MODE_0_5, MODE_1_5:   high_limit = LIM_5V;
			MODE_0_10, MODE_2_10: high_limit = LIM_10V;
			MODE_BUS: high_limit = (OUT_KIND == KIND_ACT_V) ? LIM_10V : LIM_20MA;
			default:  high_limit = LIM_ZERO;
		endcase
	endfunction

	// Fault level for a non-keep action
	function automatic logic [15:0] fault_level(input logic [2:0] a);
		if (OUT_KIND == KIND_ACT_V) begin
			case (a)
				3'h1:    fault_level = FLT_11V;
				3'h2:    fault_level = FLT_5_5V;
				3'h3:    fault_level = FLT_1_2V;
				3'h4:    fault_level = FLT_0_6V;
				default: fault_level = LIM_ZERO;
			endcase
		end else begin
			case (a)
				3'h1:    fault_level = FLT_22_1MA;
				3'h2:    fault_level = FLT_3_4MA;
				default: fault_level = LIM_ZERO;
			endcase
		end
	endfunction

	// Saturate a value to the borders
	function automatic logic [15:0] clamp(input logic signed [41:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		if (v < $signed({26'h0, lo}))
			clamp = lo;
		else if (v > $signed({26'h0, hi}))
			clamp = hi;
		else
			clamp = v[15:0];
	endfunction

	// **********************************************************************
	// Settings registers and register port
	// **********************************************************************

	logic [2:0]        mode_reg,     mode_next;
	logic              src_reg,      src_next;
	logic              inv_reg,      inv_next;
	logic [2:0]        act_reg,      act_next;
	logic [VAL_W-1:0]  low_pt_reg,   low_pt_next;
	logic [VAL_W-1:0]  high_pt_reg,  high_pt_next;
	logic [16:0]       ext_lo_reg,   ext_lo_next;
	logic [16:0]       ext_hi_reg,   ext_hi_next;
	logic [15:0]       bus_lvl_reg,  bus_lvl_next;
	logic [6:0]        tmo_reg,      tmo_next;
	logic [VAL_W-1:0]  thr_reg,      thr_next;
	logic [7:0]        hold_t_reg,   hold_t_next;
	logic [31:0]       rdata_reg,    rdata_next;
	logic              release_cmd;
	logic              flt_s1_reg,   flt_s2_reg;

	// Status and output state read back by software
	logic              pk_act_reg;
	logic              alert_reg;
	logic              clo_reg;
	logic              chi_reg;
	logic [OUT_W-1:0]  out_reg;
	logic              en_reg;

	logic [2:0]        act_max;
	logic [16:0]       ext_lo_max;
	logic [16:0]       ext_hi_max;
	assign act_max    = (OUT_KIND == KIND_ACT_V) ? ACT_MAX_ACT_V :
		(OUT_KIND == KIND_PAS_I) ? ACT_MAX_PAS_I : ACT_MAX_ACT_I;
	assign ext_lo_max = (OUT_KIND == KIND_PAS_I) ? EXT_MAX_LO_PAS : EXT_MAX_LO_ACT;
	assign ext_hi_max = (OUT_KIND == KIND_ACT_V) ? EXT_MAX_HI_V : EXT_MAX_HI_I;

	// Writes validate and saturate; unsupported choices fall back safely
	always_comb begin
		mode_next    = mode_reg;
		src_next     = src_reg;
		inv_next     = inv_reg;
		act_next     = act_reg;
		low_pt_next  = low_pt_reg;
		high_pt_next = high_pt_reg;
		ext_lo_next  = ext_lo_reg;
		ext_hi_next  = ext_hi_reg;
		bus_lvl_next = bus_lvl_reg;
		tmo_next     = tmo_reg;
		thr_next     = thr_reg;
		hold_t_next  = hold_t_reg;
		release_cmd  = 1'b0;
		rdata_next   = 32'h0;
		if (REG_WR) begin
			case (REG_ADDR)
				OFS_CTRL: begin
					mode_next = mode_ok(REG_WDATA[CTRL_MODE_LSB +: 3]) ?
						REG_WDATA[CTRL_MODE_LSB +: 3] : MODE_OFF;
					src_next  = REG_WDATA[CTRL_SRC_BIT];
					inv_next  = REG_WDATA[CTRL_INV_BIT];
					act_next  = (REG_WDATA[CTRL_ACT_LSB +: 3] <= act_max) ?
						REG_WDATA[CTRL_ACT_LSB +: 3] : ACT_KEEP;
				end
				OFS_LOW_PT:    low_pt_next  = REG_WDATA[VAL_W-1:0];
				OFS_HIGH_PT:   high_pt_next = REG_WDATA[VAL_W-1:0];
				OFS_EXT_LOW:   ext_lo_next  = (REG_WDATA[16:0] > ext_lo_max || |REG_WDATA[31:17]) ?
					ext_lo_max : REG_WDATA[16:0];
				OFS_EXT_HIGH:  ext_hi_next  = (REG_WDATA[16:0] > ext_hi_max || |REG_WDATA[31:17]) ?
					ext_hi_max : REG_WDATA[16:0];
				OFS_BUS_LEVEL: bus_lvl_next = REG_WDATA[15:0];
				OFS_TIMEOUT:   tmo_next     = (REG_WDATA[31:0] > {25'h0, TIMEOUT_MAX}) ?
					TIMEOUT_MAX : REG_WDATA[6:0];
				OFS_PEAK_THR:  thr_next     = {1'b0, REG_WDATA[VAL_W-2:0]};
				OFS_HOLD_TIME: hold_t_next  = (REG_WDATA[31:0] > {24'h0, HOLD_MAX}) ?
					HOLD_MAX : REG_WDATA[7:0];
				OFS_CMD:       release_cmd  = REG_WDATA[CMD_REL_BIT];
				default: ;
			endcase
		end
		if (REG_RD) begin
			case (REG_ADDR)
				OFS_CTRL:      rdata_next = {24'h0, act_reg, inv_reg, src_reg, mode_reg};
				OFS_LOW_PT:    rdata_next = {{8{low_pt_reg[VAL_W-1]}}, low_pt_reg};
				OFS_HIGH_PT:   rdata_next = {{8{high_pt_reg[VAL_W-1]}}, high_pt_reg};
				OFS_EXT_LOW:   rdata_next = {15'h0, ext_lo_reg};
				OFS_EXT_HIGH:  rdata_next = {15'h0, ext_hi_reg};
				OFS_BUS_LEVEL: rdata_next = {16'h0, bus_lvl_reg};
				OFS_TIMEOUT:   rdata_next = {25'h0, tmo_reg};
				OFS_PEAK_THR:  rdata_next = {8'h0, thr_reg};
				OFS_HOLD_TIME: rdata_next = {24'h0, hold_t_reg};
				OFS_STATUS:    rdata_next = {26'h0, en_reg, chi_reg, clo_reg,
					pk_act_reg, alert_reg, flt_s2_reg};
				OFS_OUT_CODE:  rdata_next = {16'h0, out_reg};
				default:       rdata_next = 32'h0;
			endcase
		end
	end

	// Settings storage; fault pin passes two flops
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			mode_reg    <= MODE_OFF;
			src_reg     <= 1'b0;
			inv_reg     <= 1'b0;
			act_reg     <= ACT_KEEP;
			low_pt_reg  <= RST_LOW_PT;
			high_pt_reg <= RST_HIGH_PT;
			ext_lo_reg  <= 17'h0;
			ext_hi_reg  <= 17'h0;
			bus_lvl_reg <= 16'h0;
			tmo_reg     <= 7'h0;
			thr_reg     <= RST_PEAK_THR;
			hold_t_reg  <= 8'h0;
			rdata_reg   <= 32'h0;
			flt_s1_reg  <= 1'b0;
			flt_s2_reg  <= 1'b0;
		end else begin
			mode_reg    <= mode_next;
			src_reg     <= src_next;
			inv_reg     <= inv_next;
			act_reg     <= act_next;
			low_pt_reg  <= low_pt_next;
			high_pt_reg <= high_pt_next;
			ext_lo_reg  <= ext_lo_next;
			ext_hi_reg  <= ext_hi_next;
			bus_lvl_reg <= bus_lvl_next;
			tmo_reg     <= tmo_next;
			thr_reg     <= thr_next;
			hold_t_reg  <= hold_t_next;
			rdata_reg   <= rdata_next;
			flt_s1_reg  <= FAULT_IN;
			flt_s2_reg  <= flt_s1_reg;
		end
	end

	// **********************************************************************
	// Tenth-second tick, frame supervision, peak hold
	// **********************************************************************

	logic [31:0]      tenth_cnt_reg, tenth_cnt_next;
	logic             tick;
	logic [9:0]       gap_reg,       gap_next;
	logic             alert_next;
	logic [VAL_W-1:0] pk_ext_reg,    pk_ext_next;
	logic [VAL_W-1:0] pk_held_reg,   pk_held_next;
	logic             pk_act_next;
	logic [7:0]       pk_tmr_reg,    pk_tmr_next;
	logic [VAL_W:0]   pk_swing;
	logic [VAL_W-1:0] pk_top;
	logic [9:0]       gap_limit;

	assign tick      = (tenth_cnt_reg == TENTH_CYC - 1);
	assign gap_limit = 10'(tmo_reg) * 10'(TENTHS_PER_S);

	always_comb begin
		tenth_cnt_next = tick ? 32'h0 : tenth_cnt_reg + 32'h1;
		// Gap counter saturates so a silent bus cannot wrap back to healthy
		gap_next = FRAME_RX ? 10'h0 : ((tick && gap_reg != 10'h3ff) ? gap_reg + 10'h1 : gap_reg);
		// Raising the alert wins over a frame in the same cycle
		if (tmo_reg != 7'h0 && gap_reg > gap_limit && !alert_reg)
			alert_next = 1'b1;
		else if (FRAME_RX || tmo_reg == 7'h0)
			alert_next = 1'b0;
		else
			alert_next = alert_reg;

		// Track the running extreme and its swing back
		if (!inv_reg) begin
			pk_top   = ($signed(MEAS_VALUE) > $signed(pk_ext_reg)) ? MEAS_VALUE : pk_ext_reg;
			pk_swing = {pk_top[VAL_W-1], pk_top} - {MEAS_VALUE[VAL_W-1], MEAS_VALUE};
		end else begin
			pk_top   = ($signed(MEAS_VALUE) < $signed(pk_ext_reg)) ? MEAS_VALUE : pk_ext_reg;
			pk_swing = {MEAS_VALUE[VAL_W-1], MEAS_VALUE} - {pk_top[VAL_W-1], pk_top};
		end
		pk_ext_next  = pk_top;
		pk_held_next = pk_held_reg;
		pk_act_next  = pk_act_reg;
		pk_tmr_next  = pk_tmr_reg;
		if ($signed(pk_swing) >= $signed({1'b0, thr_reg})) begin
			pk_held_next = pk_top;
			pk_act_next  = 1'b1;
			pk_tmr_next  = hold_t_reg;
			pk_ext_next  = MEAS_VALUE;
		end else if (release_cmd) begin
			pk_act_next = 1'b0;
		end else if (pk_act_reg && tick && pk_tmr_reg != 8'h0) begin
			// Zero hold time keeps the value until software releases it
			pk_tmr_next = pk_tmr_reg - 8'h1;
			if (pk_tmr_reg == 8'h1)
				pk_act_next = 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			tenth_cnt_reg <= 32'h0;
			gap_reg       <= 10'h0;
			alert_reg     <= 1'b0;
			pk_ext_reg    <= {VAL_W{1'b0}};
			pk_held_reg   <= {VAL_W{1'b0}};
			pk_act_reg    <= 1'b0;
			pk_tmr_reg    <= 8'h0;
		end else begin
			tenth_cnt_reg <= tenth_cnt_next;
			gap_reg       <= gap_next;
			alert_reg     <= alert_next;
			pk_ext_reg    <= pk_ext_next;
			pk_held_reg   <= pk_held_next;
			pk_act_reg    <= pk_act_next;
			pk_tmr_reg    <= pk_tmr_next;
		end
	end

	// **********************************************************************
	// Scaling engine: one serial division per update
	// **********************************************************************

	typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_FIX} aos_state_e;

	aos_state_e       st_reg,   st_next;
	logic [39:0]      num_reg,  num_next;
	logic [24:0]      rem_reg,  rem_next;
	logic [24:0]      den_reg,  den_next;
	logic             neg_reg,  neg_next;
	logic [5:0]       cnt_reg,  cnt_next;
	logic [15:0]      calc_reg, calc_next;
	logic             clo_next, chi_next;
	logic [15:0]      lim_lo, lim_hi, bord_lo, bord_hi;
	logic [31:0]      cut_lo, cut_hi;
	logic [VAL_W-1:0] src_val;
	logic [24:0]      diff, span_den, mag_diff;
	logic [25:0]      rem_sh;
	logic signed [41:0] sval;

	assign lim_lo  = low_limit(mode_reg);
	assign lim_hi  = high_limit(mode_reg);
	assign cut_lo  = (32'(lim_lo) * 32'(ext_lo_reg)) / EXT_SCALE;
	assign cut_hi  = (32'(lim_hi) * 32'(ext_hi_reg)) / EXT_SCALE;
	assign bord_lo = lim_lo - cut_lo[15:0];
	assign bord_hi = lim_hi + cut_hi[15:0];
	assign src_val = (src_reg && pk_act_reg) ? pk_held_reg : MEAS_VALUE;

	always_comb begin
		st_next   = st_reg;
		num_next  = num_reg;
		rem_next  = rem_reg;
		den_next  = den_reg;
		neg_next  = neg_reg;
		cnt_next  = cnt_reg;
		calc_next = calc_reg;
		clo_next  = clo_reg;
		chi_next  = chi_reg;
		diff      = {src_val[VAL_W-1], src_val} - {low_pt_reg[VAL_W-1], low_pt_reg};
		span_den  = {high_pt_reg[VAL_W-1], high_pt_reg} - {low_pt_reg[VAL_W-1], low_pt_reg};
		mag_diff  = diff[24] ? 25'(-diff) : diff;
		rem_sh    = {rem_reg, num_reg[39]};
		sval      = 42'sh0;
		case (st_reg)
			ST_IDLE: begin
				if (span_den == 25'h0) begin
					calc_next = bord_lo;
					clo_next  = 1'b1;
					chi_next  = 1'b0;
				end else begin
					// Sign kept apart so an inverted pair just flips it
					num_next = 40'(mag_diff) * 40'(lim_hi - lim_lo);
					neg_next = diff[24] ^ span_den[24];
					den_next = span_den[24] ? 25'(-span_den) : span_den;
					rem_next = 25'h0;
					cnt_next = 6'd40;
					st_next  = ST_DIV;
				end
			end
			ST_DIV: begin
				// Restoring division, one quotient bit per cycle
				if (rem_sh >= {1'b0, den_reg}) begin
					rem_next = 25'(rem_sh - {1'b0, den_reg});
					num_next = {num_reg[38:0], 1'b1};
				end else begin
					rem_next = rem_sh[24:0];
					num_next = {num_reg[38:0], 1'b0};
				end
				cnt_next = cnt_reg - 6'd1;
				if (cnt_reg == 6'd1)
					st_next = ST_FIX;
			end
			ST_FIX: begin
				sval = (neg_reg ? -$signed({2'b00, num_reg}) : $signed({2'b00, num_reg})) +
					$signed({26'h0, lim_lo});
				calc_next = clamp(sval, bord_lo, bord_hi);
				clo_next  = sval < $signed({26'h0, bord_lo});
				chi_next  = sval > $signed({26'h0, bord_hi});
				st_next   = ST_IDLE;
			end
			default: st_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			st_reg   <= ST_IDLE;
			num_reg  <= 40'h0;
			rem_reg  <= 25'h0;
			den_reg  <= 25'h0;
			neg_reg  <= 1'b0;
			cnt_reg  <= 6'h0;
			calc_reg <= 16'h0;
			clo_reg  <= 1'b0;
			chi_reg  <= 1'b0;
		end else begin
			st_reg   <= st_next;
			num_reg  <= num_next;
			rem_reg  <= rem_next;
			den_reg  <= den_next;
			neg_reg  <= neg_next;
			cnt_reg  <= cnt_next;
			calc_reg <= calc_next;
			clo_reg  <= clo_next;
			chi_reg  <= chi_next;
		end
	end

	// **********************************************************************
	// Output selection
	// **********************************************************************

	logic [OUT_W-1:0] out_next;
	logic             en_next;
	logic             crit;

	assign crit = flt_s2_reg || (mode_reg == MODE_BUS && alert_reg);

	// Fault override only while critical; normal path resumes after
	always_comb begin
		en_next  = 1'b1;
		out_next = calc_reg;
		if (mode_reg == MODE_OFF) begin
			en_next  = 1'b0;
			out_next = 16'h0;
		end else if (crit) begin
			out_next = (act_reg == ACT_KEEP) ? out_reg : fault_level(act_reg);
		end else if (mode_reg == MODE_BUS) begin
			out_next = clamp({26'h0, bus_lvl_reg}, bord_lo, bord_hi);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			out_reg <= 16'h0;
			en_reg  <= 1'b0;
		end else begin
			out_reg <= out_next;
			en_reg  <= en_next;
		end
	end

	assign OUT_CODE   = out_reg;
	assign OUT_ENABLE = en_reg;
	assign BUS_ALERT  = alert_reg;
	assign REG_RDATA  = rdata_reg;

endmodule // aos_analog_out
`default_nettype wire

// ---- aos_analog_out_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// Output checker
// ****************
module aos_analog_out_monitor
	import aos_pkg::*;
#(
	parameter int unsigned TENTH_CYC = 20
) (
	// Clock, reset and register port
	input wire logic             CLOCK,
	input wire logic             RST_N,
	input wire logic [7:0]       REG_ADDR,
	input wire logic [31:0]      REG_WDATA,
	input wire logic             REG_WR,
	input wire logic             REG_RD,
	input wire logic [31:0]      REG_RDATA,
	// Events and output stage
	input wire logic [VAL_W-1:0] MEAS_VALUE,
	input wire logic             FRAME_RX,
	input wire logic             FAULT_IN,
	input wire logic [OUT_W-1:0] OUT_CODE,
	input wire logic             OUT_ENABLE,
	input wire logic             BUS_ALERT
);
	logic [31:0] gap_reg;
	logic [31:0] gap_next;
	// Cycles since last frame; an alert needs at least a 0.9 s gap
	always_comb gap_next = FRAME_RX ? 32'h0 : gap_reg + 32'h1;
	always_ff @(posedge CLOCK) gap_reg <= RST_N ? gap_next : 32'h0;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	a_code_ceiling: assert property (OUT_CODE <= 16'h5dc0)
		else $error("output code above widest border");
	a_alert_gap: assert property ($rose(BUS_ALERT) |-> $past(gap_reg) >= 9 * TENTH_CYC)
		else $error("alert raised before frame gap ran out");
	a_alert_clear: assert property ($fell(BUS_ALERT) |-> $past(FRAME_RX) || $past(REG_WR, 2))
		else $error("alert dropped without frame or write");
	a_rd_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("read data outside read slot");
	a_rd_code: assert property (REG_RD && REG_ADDR == OFS_OUT_CODE |=> REG_RDATA == {16'h0, $past(OUT_CODE)})
		else $error("code readback differs");
	a_rd_unmapped: assert property (REG_RD && REG_ADDR == 8'h30 |=> REG_RDATA == 32'h0)
		else $error("unmapped read not zero");
	a_mode_on: assert property (REG_WR && REG_ADDR == OFS_CTRL && REG_WDATA[2:0] == MODE_4_20 |-> ##[1:3] OUT_ENABLE)
		else $error("enable missing after mode write");
	a_mode_off: assert property (REG_WR && REG_ADDR == OFS_CTRL && REG_WDATA[2:0] == MODE_OFF |-> ##[1:50] (!OUT_ENABLE && OUT_CODE == 16'h0))
		else $error("disabled output not zero");
	// Main scenarios
	c_alert_frame: cover property (BUS_ALERT && FRAME_RX);
	c_enable: cover property ($rose(OUT_ENABLE));
	c_fault_high: cover property (FAULT_IN && OUT_CODE == FLT_22_1MA);
endmodule // aos_analog_out_monitor
bind aos_analog_out aos_analog_out_monitor #(.TENTH_CYC(TENTH_CYC)) i_mon (.CLOCK(CLOCK),
	.RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .MEAS_VALUE(MEAS_VALUE), .FRAME_RX(FRAME_RX), .FAULT_IN(FAULT_IN),
	.OUT_CODE(OUT_CODE), .OUT_ENABLE(OUT_ENABLE), .BUS_ALERT(BUS_ALERT));
`default_nettype wire

// ---- aos_stage_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// Output stage model
// ****************
module aos_stage_model
	import aos_pkg::*;
(
	// Setpoint from the block
	input  wire logic             clock,
	input  wire logic [OUT_W-1:0] code,
	input  wire logic             enable,
	// Level delivered to the loop
	output logic      [OUT_W-1:0] level
);
	logic [OUT_W-1:0] level_reg;
	logic [OUT_W-1:0] level_next;
	// Settles a cycle late; sources nothing while switched off
	always_comb level_next = enable ? code : 16'h0;
	always_ff @(posedge clock) level_reg <= level_next;
	assign level = level_reg;
endmodule // aos_stage_model
`default_nettype wire

// ---- aos_analog_out_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bench
// ****************
module aos_analog_out_bench import aos_pkg::*;;
	typedef struct {logic [2:0] m; logic [23:0] lo, hi; logic [16:0] el, eh; logic [23:0] v;
		logic [15:0] e;} aos_row_s;
	logic        clock = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, frame = 1'b0, fault = 1'b0;
	logic [7:0]  addr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [23:0] meas = 24'h0;
	logic [15:0] code, level;
	logic        en, alert;
	int          err_count = 0, tests_run = 0, i;
	logic [15:0] flt [4] = '{FLT_22_1MA, FLT_3_4MA, 16'h0, 16'h2ee0};
	aos_row_s    rows [11] = '{
		'{MODE_4_20, 24'h0, 24'h3e8, 17'h0, 17'h0, 24'h1f4, 16'h2ee0},
		'{MODE_4_20, 24'h0, 24'h3e8, 17'h0, 17'h0, 24'h3e8, 16'h4e20},
		'{MODE_4_20, 24'h0, 24'h3e8, 17'h0, 17'h0, 24'h7d0, 16'h4e20},
		'{MODE_4_20, 24'h0, 24'h3e8, 17'h0, 17'h0, 24'hffff9c, 16'h0fa0},
		'{MODE_4_20, 24'h0, 24'h3e8, 17'h0, 17'h2710, 24'h7d0, 16'h55f0},
		'{MODE_4_20, 24'h0, 24'h3e8, 17'h4e20, 17'h0, 24'hfffc18, 16'h0c80},
		'{MODE_0_20, 24'h3e8, 24'h0, 17'h0, 17'h0, 24'hfa, 16'h3a98},
		'{MODE_0_20, 24'h0, 24'h3e8, 17'h0, 17'h0, 24'h14d, 16'h1a04},
		'{MODE_0_20, 24'h1f4, 24'h1f4, 17'h0, 17'h0, 24'h2bc, 16'h0},
		'{MODE_0_5, 24'h0, 24'h3e8, 17'h0, 17'h0, 24'h1f4, 16'h0},
		'{MODE_OFF, 24'h0, 24'h3e8, 17'h0, 17'h0, 24'h1f4, 16'h0}};
	// Clock and parts
	always #2 clock = ~clock;
	aos_analog_out #(.OUT_KIND(KIND_ACT_I), .TENTH_CYC(20)) i_dut (.CLOCK(clock), .RST_N(rst_n),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.MEAS_VALUE(meas), .FRAME_RX(frame), .FAULT_IN(fault), .OUT_CODE(code),
		.OUT_ENABLE(en), .BUS_ALERT(alert));
	aos_stage_model i_stage (.clock(clock), .code(code), .enable(en), .level(level));
	// Compare, count, report at once
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Strobes get a quiet cycle after them so no signal is set twice per step
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk(rdata, e);
		@(posedge clock);
	endtask
	task automatic summarize;
		if (err_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Table, then saturation, fault, bus and reset cases
	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rchk(OFS_HIGH_PT, 32'h3e8);
		foreach (rows[k]) begin
			wreg(OFS_CTRL, {29'h0, rows[k].m});
			wreg(OFS_LOW_PT, {8'h0, rows[k].lo});
			wreg(OFS_HIGH_PT, {8'h0, rows[k].hi});
			wreg(OFS_EXT_LOW, {15'h0, rows[k].el});
			wreg(OFS_EXT_HIGH, {15'h0, rows[k].eh});
			meas <= rows[k].v;
			repeat (100) @(posedge clock);
			chk(code, {16'h0, rows[k].e});
			chk(level, {16'h0, rows[k].e});
			rchk(OFS_OUT_CODE, {16'h0, rows[k].e});
		end
		wreg(OFS_EXT_LOW, 32'h1ffff);
		rchk(OFS_EXT_LOW, {15'h0, EXT_MAX_LO_ACT});
		wreg(OFS_EXT_HIGH, 32'h1ffff);
		rchk(OFS_EXT_HIGH, {15'h0, EXT_MAX_HI_I});
		rchk(8'h30, 32'h0);
		wreg(OFS_CTRL, 32'h0a);
		meas <= 24'h3e8;
		repeat (3) @(posedge clock);
		meas <= 24'h1f4;
		repeat (100) @(posedge clock);
		chk(code, 32'h4e20);
		wreg(OFS_CMD, 32'h1);
		repeat (100) @(posedge clock);
		chk(code, 32'h2ee0);
		foreach (flt[k]) begin
			wreg(OFS_CTRL, {24'h0, 3'(k + 1), 2'h0, MODE_4_20});
			fault <= 1'b1;
			repeat (4) @(posedge clock);
			chk(code, {16'h0, flt[k]});
			fault <= 1'b0;
			repeat (100) @(posedge clock);
			chk(code, 32'h2ee0);
		end
		wreg(OFS_CTRL, {24'h0, 3'h2, 2'h0, MODE_BUS});
		wreg(OFS_BUS_LEVEL, 32'h1388);
		frame <= 1'b1;
		@(posedge clock);
		frame <= 1'b0;
		wreg(OFS_TIMEOUT, 32'h1);
		chk(code, 32'h1388);
		for (i = 0; i < 400 && alert !== 1'b1; i++) @(posedge clock);
		if (i == 400) begin
			err_count++;
			summarize();
		end
		repeat (3) @(posedge clock);
		chk(code, {16'h0, FLT_3_4MA});
		frame <= 1'b1;
		@(posedge clock);
		frame <= 1'b0;
		repeat (3) @(posedge clock);
		chk({alert, code}, 32'h1388);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		chk({alert, en, code}, 32'h0);
		summarize();
	end
endmodule // aos_analog_out_bench
`default_nettype wire
